/* bench/charger_status_voltage_check_checker.sv */
// Purpose: port-level assertions for the status and voltage block
// Assumes: one clock, synchronous active-high reset, CE held high
// Notes:   pin-based checks allow slack for the synchronisers
`timescale 1ns/1ps
module status_voltage_checker
   import charger_pkg::*;
#(
   parameter int BYPASS_DEGLITCH_CYCLES = 20,
   parameter int ALERT_DELAY_CYCLES     = 30
) (
   input wire logic        CLOCK,
   input wire logic        SRST,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [7:0]  REG_CMD,
   input wire logic [15:0] REG_WDATA,
   input wire logic [15:0] REG_RDATA,
   input wire logic        ADAPTER_DETECT_PIN,
   input wire logic        THERMISTOR_PIN,
   input wire logic        INPUT_MARGIN_PIN,
   input wire logic        INPUT_RESTORE_PIN,
   input wire logic        BUS_ENABLE,
   input wire logic        CHARGE_ENABLE,
   input wire logic [15:0] CHARGE_TARGET_MV,
   input wire logic [2:0]  CELL_COUNT,
   input wire logic        BATTERY_PATH_DRIVE,
   input wire logic        ADAPTER_PATH_DRIVE,
   input wire logic        BYPASS_DRIVE,
   input wire logic        ALERT
);
   int hold_cnt_ff;
   int en_cnt_ff;
   // pin-level count leads the synced one, but a one-cycle dip that the synchroniser filters out clears only this count
   always_ff @(posedge CLOCK) begin
      if (SRST || !(INPUT_MARGIN_PIN && INPUT_RESTORE_PIN))
         hold_cnt_ff <= 0;
      else if (hold_cnt_ff < 1000000)
         hold_cnt_ff <= hold_cnt_ff + 1;
   end
   always_ff @(posedge CLOCK) begin
      if (SRST || !BUS_ENABLE)
         en_cnt_ff <= 0;
      else if (en_cnt_ff < 1000000)
         en_cnt_ff <= en_cnt_ff + 1;
   end
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SRST);
   sequence s_volt_wr;
      REG_WR && BUS_ENABLE && REG_CMD == CMD_VOLTAGE;
   endsequence
   sequence s_bad_wr;
      s_volt_wr ##0 (REG_WDATA != V_WAKE && (REG_WDATA < V_LO_MIN ||
         (REG_WDATA > V_LO_MAX + 16'h000F && REG_WDATA < V_HI_MIN)));
   endsequence
   sequence s_big_wr;
      s_volt_wr ##0 REG_WDATA > V_HI_MAX;
   endsequence
   sequence s_stat_rd;
      REG_RD && BUS_ENABLE && REG_CMD == CMD_STATUS;
   endsequence
   a_bad_volt_off: assert property (
      s_bad_wr |-> ##[1:6] (!CHARGE_ENABLE && CHARGE_TARGET_MV == ZERO_WORD))
      else $error("bad voltage left charging on");
   a_big_volt_clamp: assert property (
      s_big_wr |-> ##[1:6] (CHARGE_TARGET_MV == V_HI_MAX && CHARGE_ENABLE))
      else $error("high voltage not clamped");
   a_target_step: assert property (
      CHARGE_TARGET_MV != V_WAKE |-> CHARGE_TARGET_MV[3:0] == 4'h0)
      else $error("target not on a step");
   a_target_band: assert property (
      CHARGE_TARGET_MV != ZERO_WORD |-> (CHARGE_TARGET_MV == V_WAKE ||
      CHARGE_TARGET_MV inside {[V_LO_MIN:V_LO_MAX], [V_HI_MIN:V_HI_MAX]}))
      else $error("target outside the bands");
   a_hi_band_cells: assert property (
      (CHARGE_TARGET_MV >= V_HI_MIN) [*2] |-> CELL_COUNT == CELLS_HI)
      else $error("upper band without four cells");
   a_paths_exclusive: assert property (
      !(BATTERY_PATH_DRIVE && ADAPTER_PATH_DRIVE))
      else $error("both path drives on");
   a_no_adapter_idle: assert property (
      !ADAPTER_DETECT_PIN [*8] |-> !CHARGE_ENABLE)
      else $error("charging without adapter");
   a_no_battery_stop: assert property (
      !THERMISTOR_PIN [*8] |-> !CHARGE_ENABLE)
      else $error("charging without battery");
   a_bypass_cut: assert property (
      !INPUT_MARGIN_PIN [*7] |-> !BYPASS_DRIVE)
      else $error("bypass kept on without margin");
   a_bypass_wait: assert property (
      $rose(BYPASS_DRIVE) |-> hold_cnt_ff >= BYPASS_DEGLITCH_CYCLES)
      else $error("bypass back on too early");
   a_alert_delay: assert property (
      $rose(ALERT) |-> en_cnt_ff >= ALERT_DELAY_CYCLES - 2)
      else $error("alert too early");
   a_status_low_zero: assert property (
      s_stat_rd |=> REG_RDATA[10:0] == 11'h000)
      else $error("status low bits not zero");
endmodule : status_voltage_checker

bind charger_status_voltage_check status_voltage_checker #(
   .BYPASS_DEGLITCH_CYCLES(BYPASS_DEGLITCH_CYCLES),
   .ALERT_DELAY_CYCLES(ALERT_DELAY_CYCLES)
) u_chk (
   .CLOCK(CLOCK), .SRST(SRST), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_CMD(REG_CMD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .ADAPTER_DETECT_PIN(ADAPTER_DETECT_PIN), .THERMISTOR_PIN(THERMISTOR_PIN),
   .INPUT_MARGIN_PIN(INPUT_MARGIN_PIN), .INPUT_RESTORE_PIN(INPUT_RESTORE_PIN),
   .BUS_ENABLE(BUS_ENABLE), .CHARGE_ENABLE(CHARGE_ENABLE),
   .CHARGE_TARGET_MV(CHARGE_TARGET_MV), .CELL_COUNT(CELL_COUNT),
   .BATTERY_PATH_DRIVE(BATTERY_PATH_DRIVE),
   .ADAPTER_PATH_DRIVE(ADAPTER_PATH_DRIVE),
   .BYPASS_DRIVE(BYPASS_DRIVE), .ALERT(ALERT)
);

/* bench/host_model.sv */
// Purpose: host controller side of the decoded register port
// Assumes: strobes raised and dropped on rising clock edges
// Notes:   idle command and data show the inverse of the last value
`timescale 1ns/1ps
module host_model (
   input  wire logic        clk,
   output logic             reg_wr    = 1'b0,
   output logic             reg_rd    = 1'b0,
   output logic [7:0]       reg_cmd   = 8'h00,
   output logic [15:0]      reg_wdata = 16'h0000,
   input  wire logic [15:0] reg_rdata
);
   task automatic wr_word(input logic [7:0] cmd, input logic [15:0] data);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_cmd   <= cmd;
      reg_wdata <= data;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_cmd   <= ~cmd;
      reg_wdata <= ~data;
   endtask : wr_word

   // read word is taken once the strobe edge has landed
   task automatic rd_word(input logic [7:0] cmd, output logic [15:0] data);
      @(posedge clk);
      reg_rd  <= 1'b1;
      reg_cmd <= cmd;
      @(posedge clk);
      reg_rd  <= 1'b0;
      reg_cmd <= ~cmd;
      #1 data = reg_rdata;
   endtask : rd_word
endmodule : host_model

/* bench/tb_charger_status_voltage_check.sv */
// Purpose: self-checking bench for the status and voltage block
// Assumes: small deglitch and alert counts keep the run short
// Notes:   voltage cases in a table, the rest hand-written
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   mismatches++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_charger_status_voltage_check;
   import charger_pkg::*;
   typedef struct packed {
      logic [15:0] wr;
      logic [15:0] tgt;
      logic [2:0]  cells;
   } vrow_t;
   // zero target marks an out-of-range case, zero cells skips that check
   localparam vrow_t ROWS [12] = '{
      {16'h2328, 16'h2328, 3'h3}, {16'h2EDF, 16'h0000, 3'h0},
      {16'h2EEF, 16'h2EE0, 3'h3}, {16'h2327, 16'h0000, 3'h0},
      {16'h3840, 16'h3840, 3'h3}, {16'h3850, 16'h0000, 3'h0},
      {16'h3E80, 16'h3E80, 3'h4}, {16'h3E7F, 16'h0000, 3'h0},
      {16'h4B01, 16'h4B00, 3'h4}, {16'h4B00, 16'h4B00, 3'h4},
      {16'h0000, 16'h0000, 3'h0}, {16'hFFFF, 16'h4B00, 3'h4}};
   logic        clock = 1'b0, srst = 1'b1, ce = 1'b1, por = 1'b0;
   logic        sup_ok = 1'b1, adp = 1'b1, therm = 1'b1, sense = 1'b0;
   logic        margin = 1'b1, restore = 1'b1;
   logic        wr, rdq, bus_en, chg_en, bat_drv, adp_drv, bypass, alert;
   logic [7:0]  cmd;
   logic [15:0] wdata, rdata, target, rd, bat_mv = 16'h3A98;
   logic [2:0]  cells;
   int          mismatches = 0, n_checks = 0;

   always #2 clock = ~clock;

   charger_status_voltage_check #(
      .BYPASS_DEGLITCH_CYCLES(20), .ALERT_DELAY_CYCLES(30)
   ) u_dut (
      .CLOCK(clock), .SRST(srst), .CE(ce), .REG_WR(wr), .REG_RD(rdq),
      .REG_CMD(cmd), .REG_WDATA(wdata), .REG_RDATA(rdata), .BAT_MV(bat_mv),
      .ADAPTER_DETECT_PIN(adp), .ADAPTER_DETECT_POR_PIN(por),
      .SUPPLY_OK_PIN(sup_ok), .THERMISTOR_PIN(therm),
      .ADAPTER_SENSE_PIN(sense), .INPUT_MARGIN_PIN(margin),
      .INPUT_RESTORE_PIN(restore), .BUS_ENABLE(bus_en),
      .CHARGE_ENABLE(chg_en), .CHARGE_TARGET_MV(target), .CELL_COUNT(cells),
      .BATTERY_PATH_DRIVE(bat_drv), .ADAPTER_PATH_DRIVE(adp_drv),
      .BYPASS_DRIVE(bypass), .ALERT(alert));

   host_model u_host (.clk(clock), .reg_wr(wr), .reg_rd(rdq),
      .reg_cmd(cmd), .reg_wdata(wdata), .reg_rdata(rdata));

   ////////////////////////////////////////////////////////////////////////
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wt

   // exp holds depleted flag, battery drive, adapter drive
   task automatic chk_dep(input logic [15:0] mv, input logic [2:0] exp);
      @(posedge clock);
      bat_mv <= mv;
      wt(5);
      u_host.rd_word(CMD_STATUS, rd);
      `CHK("depleted", exp[2], rd[ST_DEPLETED])
      `CHK("drives", exp[1:0], {bat_drv, adp_drv})
   endtask : chk_dep

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      wt(10);
      `CHK("bus off", 1'b0, bus_en)
      @(posedge clock);
      por <= 1'b1;
      wt(10);
      `CHK("bus on", 1'b1, bus_en)
      foreach (ROWS[i]) begin
         u_host.wr_word(CMD_VOLTAGE, ROWS[i].wr);
         wt(5);
         u_host.rd_word(CMD_STATUS, rd);
         `CHK("target", ROWS[i].tgt, target)
         `CHK("range", ROWS[i].tgt == 16'h0000, rd[ST_RANGE])
         `CHK("charge", ROWS[i].tgt != 16'h0000, chg_en)
         if (ROWS[i].cells != 3'h0)
            `CHK("cells", ROWS[i].cells, cells)
      end
      // flags, refused write, unmapped read
      u_host.wr_word(CMD_VOLTAGE, 16'h2EE0);
      @(posedge clock);
      sense <= 1'b1;
      wt(8);
      u_host.rd_word(CMD_STATUS, rd);
      `CHK("status", 16'hE000, rd)
      u_host.wr_word(CMD_STATUS, 16'h0000);
      u_host.rd_word(CMD_STATUS, rd);
      `CHK("status kept", 16'hE000, rd)
      u_host.rd_word(8'h14, rd);
      `CHK("unmapped", 16'h0000, rd)
      u_host.rd_word(CMD_VOLTAGE, rd);
      `CHK("voltage", 16'h2EE0, rd)
      // three cells at code 0, then four cells at code 1 with learn
      chk_dep(16'h20CF, 3'b101);
      chk_dep(16'h20D0, 3'b001);
      u_host.wr_word(CMD_CONTROL, 16'h0210);
      u_host.rd_word(CMD_CONTROL, rd);
      `CHK("control", 16'h0210, rd)
      u_host.wr_word(CMD_VOLTAGE, 16'h3E80);
      chk_dep(16'h2D50, 3'b010);
      chk_dep(16'h2D4F, 3'b101);
      @(posedge clock);
      bat_mv <= 16'h4650;
      therm  <= 1'b0;
      wt(8);
      `CHK("no battery", 1'b0, chg_en)
      u_host.rd_word(CMD_STATUS, rd);
      `CHK("battery flag", 1'b0, rd[ST_BAT_DET])
      @(posedge clock);
      therm <= 1'b1;
      adp   <= 1'b0;
      wt(8);
      `CHK("no adapter", 1'b0, chg_en)
      u_host.rd_word(CMD_STATUS, rd);
      `CHK("adapter flag", 1'b0, rd[ST_ADP_DET])
      @(posedge clock);
      adp <= 1'b1;
      wt(60);
      u_host.rd_word(CMD_STATUS, rd);
      `CHK("alert cleared", 1'b0, alert)
      @(posedge clock);
      sense <= 1'b0;
      wt(20);
      `CHK("alert early", 1'b0, alert)
      wt(25);
      `CHK("alert late", 1'b1, alert)
      // restore low must keep the bypass off
      `CHK("bypass on", 1'b1, bypass)
      @(posedge clock);
      margin  <= 1'b0;
      restore <= 1'b0;
      wt(6);
      `CHK("bypass cut", 1'b0, bypass)
      @(posedge clock);
      margin <= 1'b1;
      wt(32);
      `CHK("hysteresis", 1'b0, bypass)
      @(posedge clock);
      restore <= 1'b1;
      wt(12);
      `CHK("deglitch", 1'b0, bypass)
      wt(20);
      `CHK("bypass back", 1'b1, bypass)
      @(posedge clock);
      srst <= 1'b1;
      wt(2);
      `CHK("reset charge", 1'b0, chg_en)
      `CHK("reset cells", 3'h3, cells)
      @(posedge clock);
      srst <= 1'b0;
      wt(10);
      `CHK("bus back", 1'b1, bus_en)
      // supply alone must also hold the bus off
      @(posedge clock);
      sup_ok <= 1'b0;
      wt(8);
      `CHK("supply low", 1'b0, bus_en)
      summarize();
   end
endmodule : tb_charger_status_voltage_check

/* hdl/charger_pkg.sv */
// Purpose: constants shared by the charger status and voltage check logic
// Assumes: 250 MHz core clock, millivolt codes on the register side
// Notes:   status word holds only the upper five flags, low bits read zero
//
// How it works
// - depleted flag high while battery under threshold
// - threshold per cell, times three or four
// - depletion cuts battery path, in learn enables adapter
// - out-of-range flag tracks invalid voltage setting
// - accept 9 V or bands, truncate to step
// - above maximum: charge on, target clamped
// - low or gap setting: charge off, alert
// - wake-up code regulates to 9 V
// - adapter-below-battery flag follows sense comparator
// - bypass off at once when margin lost
// - bypass back on after 8 ms deglitch
// - battery-detected flag follows thermistor comparator
// - no battery stops charge immediately
// - adapter-detected flag is status bit 15
// - no charging without adapter detected
// - power-on released by detect and supply
// - alert 6 to 10 ms after first toggle, later toggles ride along
package charger_pkg;

   localparam int          CLK_MHZ          = 250;
   localparam int          DATA_W           = 16;
   localparam int          CMD_W            = 8;

   // register commands
   localparam logic [7:0]  CMD_CONTROL      = 8'h12;
   localparam logic [7:0]  CMD_STATUS       = 8'h13;
   localparam logic [7:0]  CMD_VOLTAGE      = 8'h15;

   // status bit positions
   localparam int          ST_DEPLETED      = 11;
   localparam int          ST_RANGE         = 12;
   localparam int          ST_ADP_BELOW     = 13;
   localparam int          ST_BAT_DET       = 14;
   localparam int          ST_ADP_DET       = 15;

   // control fields
   localparam int          CTL_LEARN        = 4;
   localparam int          CTL_DEPL_LSB     = 9;
   localparam int          CTL_DEPL_W       = 3;

   localparam logic [15:0] CONTROL_RST      = 16'h0000;
   localparam logic [15:0] VOLTAGE_RST      = 16'h0000;
   localparam logic [15:0] ZERO_WORD        = 16'h0000;

   // charge voltage codes in mV
   localparam logic [15:0] V_WAKE           = 16'h2328;
   localparam logic [15:0] V_LO_MIN         = 16'h2EE0;
   localparam logic [15:0] V_LO_MAX         = 16'h3840;
   localparam logic [15:0] V_HI_MIN         = 16'h3E80;
   localparam logic [15:0] V_HI_MAX         = 16'h4B00;
   localparam int          V_STEP_SHIFT     = 4;

   localparam logic [2:0]  CELLS_LO         = 3'h3;
   localparam logic [2:0]  CELLS_HI         = 3'h4;

   // per-cell depletion threshold: base + code * step, in mV
   localparam logic [15:0] DEPL_BASE_MV     = 16'h0AF0;
   localparam logic [15:0] DEPL_STEP_MV     = 16'h0064;

   // timing
   localparam int          BYPASS_DEGLITCH_MS = 8;
   localparam int          ALERT_DELAY_MIN_MS = 6;
   localparam int          ALERT_DELAY_MAX_MS = 10;
   localparam int          BYPASS_CYCLES    = BYPASS_DEGLITCH_MS * 1000 *
                                              CLK_MHZ;
   localparam int          ALERT_CYCLES     = ALERT_DELAY_MIN_MS * 1000 *
                                              CLK_MHZ;

   localparam int          NUM_PINS         = 7;

endpackage : charger_pkg

/* hdl/charger_status_voltage_check.sv */
// Purpose: status flags and charge voltage validation of the charger
// Assumes: register access arrives decoded from the bus engine as
//          command, word and one-cycle strobes; BAT_MV from the ADC
//          on CLOCK; comparator pins are asynchronous
// Notes:   registers stay in reset until the internal power-on is good
`timescale 1ns/1ps
module charger_status_voltage_check
   import charger_pkg::*;
#(
   parameter int BYPASS_DEGLITCH_CYCLES = BYPASS_CYCLES,
   parameter int ALERT_DELAY_CYCLES     = ALERT_CYCLES
) (
   input  wire logic                          CLOCK,
   input  wire logic                          SRST,
   input  wire logic                          CE,
   // register access
   input  wire logic                          REG_WR,
   input  wire logic                          REG_RD,
   input  wire logic [charger_pkg::CMD_W-1:0] REG_CMD,
   input  wire logic [charger_pkg::DATA_W-1:0] REG_WDATA,
   output logic      [charger_pkg::DATA_W-1:0] REG_RDATA,
   // measurement and comparator pins
   input  wire logic [charger_pkg::DATA_W-1:0] BAT_MV,
   input  wire logic                          ADAPTER_DETECT_PIN,
   input  wire logic                          ADAPTER_DETECT_POR_PIN,
   input  wire logic                          SUPPLY_OK_PIN,
   input  wire logic                          THERMISTOR_PIN,
   input  wire logic                          ADAPTER_SENSE_PIN,
   input  wire logic                          INPUT_MARGIN_PIN,
   input  wire logic                          INPUT_RESTORE_PIN,
   // controls out
   output logic                               BUS_ENABLE,
   output logic                               CHARGE_ENABLE,
   output logic      [charger_pkg::DATA_W-1:0] CHARGE_TARGET_MV,
   output logic      [2:0]                    CELL_COUNT,
   output logic                               BATTERY_PATH_DRIVE,
   output logic                               ADAPTER_PATH_DRIVE,
   output logic                               BYPASS_DRIVE,
   output logic                               ALERT
);

   import charger_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic in_range(input logic [15:0] v,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction : in_range

   function automatic logic is_cmd(input logic [7:0] cmd,
                                   input logic [7:0] want);
      is_cmd = (cmd == want);
   endfunction : is_cmd

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [NUM_PINS-1:0] pins_raw;
   logic [NUM_PINS-1:0] pins_s;

   assign pins_raw = {ADAPTER_DETECT_PIN, ADAPTER_DETECT_POR_PIN,
                      SUPPLY_OK_PIN, THERMISTOR_PIN, ADAPTER_SENSE_PIN,
                      INPUT_MARGIN_PIN, INPUT_RESTORE_PIN};

   pin_sync #(
      .W       (NUM_PINS)
   ) u_sync (
      .clk     (CLOCK),
      .srst    (SRST),
      .en      (CE),
      .pin_in  (pins_raw),
      .pin_out (pins_s)
   );

   logic adapter_detect_pin;
   logic adapter_por_ok;
   logic supply_ok;
   logic thermistor_pin;
   logic adapter_sense_pin;
   logic input_margin_ok;
   logic input_restore_ok;

   assign adapter_detect_pin = pins_s[6];
   assign adapter_por_ok     = pins_s[5];
   assign supply_ok          = pins_s[4];
   assign thermistor_pin     = pins_s[3];
   assign adapter_sense_pin  = pins_s[2];
   assign input_margin_ok    = pins_s[1];
   assign input_restore_ok   = pins_s[0];

   ////////////////////////////////////////////////////////////////////////
   // internal power-on

   logic por_ok_ff;
   logic nxt_por_ok;
   logic rst_i;

   assign nxt_por_ok = adapter_por_ok & supply_ok;

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         por_ok_ff <= 1'b0;
      end else if (CE) begin
         por_ok_ff <= nxt_por_ok;
      end
   end

   // everything behind the bus restarts while power-on is low
   assign rst_i = SRST | ~por_ok_ff;

   ////////////////////////////////////////////////////////////////////////
   // writable registers

   logic [15:0] control_ff;
   logic [15:0] voltage_ff;
   logic        wr_control;
   logic        wr_voltage;

   assign wr_control = REG_WR & is_cmd(REG_CMD, CMD_CONTROL);
   assign wr_voltage = REG_WR & is_cmd(REG_CMD, CMD_VOLTAGE);

   // status has no write path, so writes to it fall through
   always_ff @(posedge CLOCK) begin
      if (rst_i) begin
         control_ff <= CONTROL_RST;
         voltage_ff <= VOLTAGE_RST;
      end else if (CE) begin
         if (wr_control) begin
            control_ff <= REG_WDATA;
         end
         if (wr_voltage) begin
            voltage_ff <= REG_WDATA;
         end
      end
   end

   logic                  learn;
   logic [CTL_DEPL_W-1:0] depl_code;

   assign learn     = control_ff[CTL_LEARN];
   assign depl_code = control_ff[CTL_DEPL_LSB +: CTL_DEPL_W];

   ////////////////////////////////////////////////////////////////////////
   // charge voltage check

   logic        v_wake;
   logic        v_lo_band;
   logic        v_hi_band;
   logic        v_over;
   logic        v_invalid;
   logic [15:0] v_trunc;
   logic [15:0] nxt_target;
   logic [2:0]  nxt_cells;

   assign v_wake    = (voltage_ff == V_WAKE);
   assign v_lo_band = in_range(voltage_ff, V_LO_MIN, V_LO_MAX);
   assign v_hi_band = in_range(voltage_ff, V_HI_MIN, V_HI_MAX);
   assign v_over    = (voltage_ff > V_HI_MAX);
   // below the low band or in the gap between bands
   assign v_invalid = ~(v_wake | v_lo_band | v_hi_band | v_over);

   // truncate down so the battery never sees more than asked for
   assign v_trunc = {voltage_ff[15:V_STEP_SHIFT],
                     V_STEP_SHIFT'(0)};

   assign nxt_target = v_wake    ? V_WAKE :
                       v_over    ? V_HI_MAX :
                       v_invalid ? ZERO_WORD :
                                   v_trunc;

   assign nxt_cells = (v_hi_band | v_over) ? CELLS_HI : CELLS_LO;

   ////////////////////////////////////////////////////////////////////////
   // depletion threshold

   logic [15:0] per_cell_mv;
   logic [18:0] total_mv;
   logic [15:0] depl_mv;
   logic        nxt_depleted;

   assign per_cell_mv = DEPL_BASE_MV +
                        16'(DEPL_STEP_MV * 16'(depl_code));
   assign total_mv    = 19'(per_cell_mv) * 19'(nxt_cells);
   assign depl_mv     = total_mv[15:0];
   assign nxt_depleted = (BAT_MV < depl_mv);

   ////////////////////////////////////////////////////////////////////////
   // status word

   logic [15:0] status_ff;
   logic [15:0] nxt_status;

   always_comb begin
      nxt_status               = ZERO_WORD;
      nxt_status[ST_DEPLETED]  = nxt_depleted;
      nxt_status[ST_RANGE]     = v_invalid;
      nxt_status[ST_ADP_BELOW] = adapter_sense_pin;
      nxt_status[ST_BAT_DET]   = thermistor_pin;
      nxt_status[ST_ADP_DET]   = adapter_detect_pin;
   end

   always_ff @(posedge CLOCK) begin
      if (rst_i) begin
         status_ff <= ZERO_WORD;
      end else if (CE) begin
         status_ff <= nxt_status;
      end
   end

   logic depleted;
   logic bat_det;
   logic adp_det;

   assign depleted = status_ff[ST_DEPLETED];
   assign bat_det  = status_ff[ST_BAT_DET];
   assign adp_det  = status_ff[ST_ADP_DET];

   ////////////////////////////////////////////////////////////////////////
   // charge enable and path drives

   logic nxt_charge;
   logic nxt_bat_drv;
   logic nxt_adp_drv;

   // no adapter, no battery or a bad setting each stop the charge
   assign nxt_charge = adp_det &
                       bat_det &
                       ~status_ff[ST_RANGE];

   assign nxt_bat_drv = ~depleted & (~adp_det | learn);
   assign nxt_adp_drv = adp_det & (~learn | depleted);

   always_ff @(posedge CLOCK) begin
      if (rst_i) begin
         CHARGE_ENABLE      <= 1'b0;
         CHARGE_TARGET_MV   <= ZERO_WORD;
         CELL_COUNT         <= CELLS_LO;
         BATTERY_PATH_DRIVE <= 1'b0;
         ADAPTER_PATH_DRIVE <= 1'b0;
      end else if (CE) begin
         CHARGE_ENABLE      <= nxt_charge;
         CHARGE_TARGET_MV   <= nxt_target;
         CELL_COUNT         <= nxt_cells;
         BATTERY_PATH_DRIVE <= nxt_bat_drv;
         ADAPTER_PATH_DRIVE <= nxt_adp_drv;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bypass transistor

   logic restore_done;
   logic restore_cond;
   logic nxt_bypass;

   // hysteresis: restore needs the higher comparator, loss the lower
   assign restore_cond = input_margin_ok & input_restore_ok;

   hold_timer #(
      .COUNT (BYPASS_DEGLITCH_CYCLES)
   ) u_bypass_deglitch (
      .clk   (CLOCK),
      .srst  (rst_i),
      .en    (CE),
      .cond  (restore_cond),
      .done  (restore_done)
   );

   assign nxt_bypass = ~input_margin_ok ? 1'b0 :
                       restore_done     ? 1'b1 :
                                          BYPASS_DRIVE;

   always_ff @(posedge CLOCK) begin
      if (rst_i) begin
         BYPASS_DRIVE <= 1'b0;
      end else if (CE) begin
         BYPASS_DRIVE <= nxt_bypass;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alert after a status toggle

   logic toggle;
   logic pending_ff;
   logic alert_due;
   logic fire;
   logic rd_status;

   assign toggle    = |(nxt_status ^ status_ff);
   assign fire      = alert_due & pending_ff;
   assign rd_status = REG_RD & is_cmd(REG_CMD, CMD_STATUS);

   // delay is timed from the first toggle, later ones ride along
   hold_timer #(
      .COUNT (ALERT_DELAY_CYCLES)
   ) u_alert_delay (
      .clk   (CLOCK),
      .srst  (rst_i),
      .en    (CE),
      .cond  (pending_ff),
      .done  (alert_due)
   );

   always_ff @(posedge CLOCK) begin
      if (rst_i) begin
         pending_ff <= 1'b0;
         ALERT      <= 1'b0;
      end else if (CE) begin
         pending_ff <= toggle | (pending_ff & ~fire);
         // a new alert outranks the read that would clear it
         ALERT      <= fire | (ALERT & ~rd_status);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path

   logic [15:0] rd_word;

   assign rd_word = is_cmd(REG_CMD, CMD_STATUS)  ? status_ff  :
                    is_cmd(REG_CMD, CMD_CONTROL) ? control_ff :
                    is_cmd(REG_CMD, CMD_VOLTAGE) ? voltage_ff :
                                                   ZERO_WORD;

   always_ff @(posedge CLOCK) begin
      if (rst_i) begin
         REG_RDATA <= ZERO_WORD;
      end else if (CE && REG_RD) begin
         REG_RDATA <= rd_word;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         BUS_ENABLE <= 1'b0;
      end else if (CE) begin
         BUS_ENABLE <= por_ok_ff;
      end
   end

endmodule : charger_status_voltage_check

/* hdl/hold_timer.sv */
// Purpose: raises done once cond has held for COUNT enabled cycles
// Assumes: cond comes from logic on the same clock
// Notes:   done drops at once when cond falls, no hold-over
`timescale 1ns/1ps
module hold_timer #(
   parameter int COUNT = 16
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic en,
   input  wire logic cond,
   output logic      done
);

   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

   logic [CW-1:0] cnt_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_ff <= '0;
         done   <= 1'b0;
      end else if (en) begin
         if (!cond) begin
            cnt_ff <= '0;
            done   <= 1'b0;
         end else if (cnt_ff == LAST) begin
            done   <= 1'b1;
         end else begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end

endmodule : hold_timer

/* hdl/pin_sync.sv */
// Purpose: three-stage synchroniser for a vector of comparator pins
// Assumes: pins are asynchronous to CLOCK
// Notes:   a bit changes only once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         en,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] agree;

   assign agree = ~(s2_ff ^ s3_ff);

   always_ff @(posedge clk) begin
      if (srst) begin
         s1_ff   <= '0;
         s2_ff   <= '0;
         s3_ff   <= '0;
         pin_out <= '0;
      end else if (en) begin
         s1_ff   <= pin_in;
         s2_ff   <= s1_ff;
         s3_ff   <= s2_ff;
         pin_out <= (agree & s3_ff) | (~agree & pin_out);
      end
   end

endmodule : pin_sync
